// ### hdl/converter_fault_protection_fsm.v
// Purpose: Per-channel fault supervision of a two-channel switching converter.
// Assumes: Comparator and pin inputs are asynchronous; one 250 MHz clock.
// Notes:   Analog regulation is outside; this block gates drives and soft-start.
//          Every comparator, enable and supply level is asynchronous to ref_clk.
//          Each one passes a two-stage synchroniser, so any reaction lags its
//          input by three to four clock edges. That is far below one switching
//          period and is accepted for every fault path here.
//          The switching period is a fixed count of ref_clk cycles. Channel 2
//          takes its pre-bias pulses half a period after channel 1.
//          Overcurrent is sampled only in the first cycles of the set pulse,
//          while the low side conducts, both in pre-bias and in run. A short
//          that is present during a restart therefore trips hiccup again at
//          once, without waiting for the full pre-bias sequence.
//          The overvoltage latch survives a thermal stop. Only a channel
//          enable or supply cycle releases it.
//          Open-loop recovery looks at each channel's own 0.75 comparator.
//          The output-ok flag has no start-up delay of its own.
`timescale 1ns/100ps
`include "fault_defs.vh"

module converter_fault_protection_fsm #(
  parameter [31:0] BLANK_CYCLES = `BLANK_CYCLES
) (
  // Clock and reset.
  input  wire       ref_clk,
  input  wire       nrst,
  // Supply and channel enables (asynchronous levels).
  input  wire       supply_valid,
  input  wire [1:0] enable,
  // Comparators per channel, bit 0 channel 1, then the shared thermal comparator (asynchronous levels).
  input  wire [1:0] overcurrent_cmp,
  input  wire [1:0] sense_above_ov,
  input  wire [1:0] sense_above_ov_low,
  input  wire [1:0] sense_above_085,
  input  wire [1:0] sense_above_080,
  input  wire [1:0] feedback_input_above_070,
  input  wire [1:0] feedback_input_above_075,
  input  wire       over_temp,
  // Tracking input near the internal reference; floats high.
  input  wire       track_near_ref,
  // Outputs per channel, then the shared thermal and channel 2 reference outputs.
  output reg  [1:0] high_side_drive,
  output reg  [1:0] low_side_drive,
  output reg  [1:0] soft_start_reset,
  output reg  [1:0] output_ok_flag,
  output reg  [1:0] overcurrent_flag,
  output reg  [1:0] overvoltage_flag,
  output reg  [1:0] open_loop_guard,
  output reg        thermal_shutdown,
  output reg        ch2_use_internal_ref
);

////////////////////////////////////////////////////////////////////////////////
// Input synchronisers. The first stage feeds only the second stage.
// Nineteen levels are synchronised: three shared, eight per-channel pairs.
localparam NSYNC = 19;
wire [NSYNC-1:0] raw_in = {track_near_ref, over_temp, supply_valid, enable,
                           overcurrent_cmp, sense_above_ov, sense_above_ov_low,
                           sense_above_085, sense_above_080,
                           feedback_input_above_070, feedback_input_above_075};
reg  [NSYNC-1:0] sync1;
reg  [NSYNC-1:0] sync2;

always @(posedge ref_clk) begin
  if (!nrst) begin
    sync1 <= {NSYNC{1'b0}};
    sync2 <= {NSYNC{1'b0}};
  end else begin
    sync1 <= raw_in;
    sync2 <= sync1;
  end
end

// Field positions follow the concatenation order of raw_in above.
// Nothing below reads sync1, so a metastable first stage cannot leak out.
wire       s_track = sync2[18];
wire       s_temp  = sync2[17];
wire       s_vld   = sync2[16];
wire [1:0] s_en    = sync2[15:14];
wire [1:0] s_oc    = sync2[13:12];
wire [1:0] s_ov    = sync2[11:10];
wire [1:0] s_ovl   = sync2[9:8];
wire [1:0] s_085   = sync2[7:6];
wire [1:0] s_080   = sync2[5:4];
wire [1:0] s_070   = sync2[3:2];
wire [1:0] s_075   = sync2[1:0];

////////////////////////////////////////////////////////////////////////////////
// Shared thermal state and channel 2 reference handover.
// Thermal hysteresis lives in the comparator, so the registered level is
// both the trip and the automatic restart condition.
always @(posedge ref_clk) begin
  if (!nrst) begin
    thermal_shutdown     <= 1'b0;
    ch2_use_internal_ref <= 1'b0;
  end else begin
    thermal_shutdown <= s_temp;
    // Floating tracking input reads high and so selects the internal reference.
    ch2_use_internal_ref <= s_track;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Per-channel supervision. Channel 2 takes its pre-bias pulses half a period out of phase.
// Each channel owns its overcurrent, overvoltage and open-loop state; only
// the thermal level and the supply level are common to both.
genvar ch;
generate
  for (ch = 0; ch < 2; ch = ch + 1) begin : chan
    wire [8:0] phase_ofs = (ch == 0) ? 9'd0 : 9'd200;
    reg  [8:0]  period_cnt;
    reg  [2:0]  state;
    reg  [31:0] blank_cnt;
    reg  [7:0]  ov_cnt;
    reg  [4:0]  pulse_cnt;
    reg  [3:0]  step;
    reg         armed;
    reg         ol_trip;
    reg         ov_low_hold;
    reg         en_q;
    reg         vld_q;
    reg         ss_done;
    // Position inside this channel's own period; ten bits keep the sum whole.
    wire [9:0]  phased = ({1'b0, period_cnt} + {1'b0, phase_ofs}) % {1'b0, `PERIOD_CYCLES};
    wire        in_set = (period_cnt < `EIGHTH_CYCLES);
    wire        in_sample = (period_cnt < `SAMPLE_CYCLES);
    wire [8:0]  ls_width = `EIGHTH_CYCLES * {5'd0, step};
    wire        run_ok = s_en[ch] && s_vld && !thermal_shutdown;
    wire        cycled = (s_en[ch] && !en_q) || (s_vld && !vld_q);

    always @(posedge ref_clk) begin
      if (!nrst) begin
        period_cnt       <= 9'd0;
        state            <= `ST_OFF;
        blank_cnt        <= 32'd0;
        ov_cnt           <= 8'd0;
        pulse_cnt        <= 5'd0;
        step             <= 4'd1;
        armed            <= 1'b0;
        ol_trip          <= 1'b0;
        ov_low_hold      <= 1'b0;
        en_q             <= 1'b0;
        vld_q            <= 1'b0;
        ss_done          <= 1'b0;
        high_side_drive[ch]  <= 1'b0;
        low_side_drive[ch]   <= 1'b0;
        soft_start_reset[ch] <= 1'b1;
        output_ok_flag[ch]   <= 1'b0;
        overcurrent_flag[ch] <= 1'b0;
        overvoltage_flag[ch] <= 1'b0;
        open_loop_guard[ch]  <= 1'b0;
      end else begin
        en_q  <= s_en[ch];
        vld_q <= s_vld;
        period_cnt <= (period_cnt == `PERIOD_CYCLES - 9'd1) ? 9'd0 : period_cnt + 9'd1;
        // Open-loop guard: hysteretic arming and non-latching trip.
        if (s_085[ch])
          armed <= 1'b1;
        else if (!s_080[ch])
          armed <= 1'b0;
        if (armed && !s_070[ch])
          ol_trip <= 1'b1;
        else if (s_075[ch])
          ol_trip <= 1'b0;
        // Trip takes priority, so a feedback level between the two
        // thresholds keeps the channel stopped rather than chattering.
        open_loop_guard[ch] <= ol_trip;
        // Overvoltage delay runs from entry into the latch until the flag rises.
        if (state == `ST_OVLATCH && !overvoltage_flag[ch])
          ov_cnt <= (ov_cnt == 8'hff) ? ov_cnt : ov_cnt + 8'd1;
        else
          ov_cnt <= 8'd0;
        // State actions. Later assignments in one branch win over earlier ones.
        case (state)
          `ST_OFF: begin
            high_side_drive[ch]  <= 1'b0;
            low_side_drive[ch]   <= 1'b0;
            soft_start_reset[ch] <= 1'b1;
            output_ok_flag[ch]   <= 1'b0;
            overvoltage_flag[ch] <= 1'b0;
            if (run_ok) begin
              state     <= `ST_PREBIAS;
              step      <= 4'd1;
              pulse_cnt <= 5'd0;
            end
          end
          `ST_PREBIAS: begin
            // Low side pulse grows by one eighth every 16 periods.
            high_side_drive[ch] <= 1'b0;
            low_side_drive[ch]  <= phased < {1'b0, ls_width};
            if (period_cnt == `PERIOD_CYCLES - 9'd1) begin
              pulse_cnt <= pulse_cnt + 5'd1;
              if (pulse_cnt == `PULSES_PER_STEP - 5'd1) begin
                pulse_cnt <= 5'd0;
                if (step == `PREBIAS_STEPS) begin
                  state <= `ST_RUN;
                  soft_start_reset[ch] <= 1'b0;
                end else
                  step <= step + 4'd1;
              end
            end
            // A short during restart is caught in the valley sample window of
            // the pre-bias pulse, so hiccup repeats without any limit.
            if (low_side_drive[ch] && s_oc[ch] && phased < `SAMPLE_CYCLES) begin
              state                <= `ST_HICCUP;
              overcurrent_flag[ch] <= 1'b1;
              low_side_drive[ch]   <= 1'b0;
              output_ok_flag[ch]   <= 1'b0;
              soft_start_reset[ch] <= 1'b1;
              blank_cnt            <= 32'd0;
            end
          end
          `ST_RUN: begin
            // Set pulse is the first eighth; high side starts when it falls.
            high_side_drive[ch] <= !in_set && !ol_trip;
            low_side_drive[ch]  <= in_set && !ol_trip;
            output_ok_flag[ch]  <= !ol_trip && s_080[ch];
            if (in_set && in_sample && low_side_drive[ch] && s_oc[ch]) begin
              state <= `ST_HICCUP;
              overcurrent_flag[ch] <= 1'b1;
              high_side_drive[ch]  <= 1'b0;
              low_side_drive[ch]   <= 1'b0;
              output_ok_flag[ch]   <= 1'b0;
              soft_start_reset[ch] <= 1'b1;
              blank_cnt <= 32'd0;
            end
            if (s_ov[ch]) begin
              high_side_drive[ch] <= 1'b0;
              low_side_drive[ch]  <= 1'b1;
              output_ok_flag[ch]  <= 1'b0;
              state       <= `ST_OVLATCH;
              ov_low_hold <= 1'b1;
            end
          end
          `ST_HICCUP: begin
            high_side_drive[ch] <= 1'b0;
            low_side_drive[ch]  <= 1'b0;
            blank_cnt <= blank_cnt + 32'd1;
            if (blank_cnt >= BLANK_CYCLES - 32'd1) begin
              overcurrent_flag[ch] <= 1'b0;
              state     <= `ST_PREBIAS;
              step      <= 4'd1;
              pulse_cnt <= 5'd0;
            end
          end
          `ST_OVLATCH: begin
            high_side_drive[ch] <= 1'b0;
            output_ok_flag[ch]  <= 1'b0;
            if ({24'd0, ov_cnt} >= `OV_DELAY_CYCLES - 1)
              overvoltage_flag[ch] <= 1'b1;
            if (!s_ovl[ch])
              ov_low_hold <= 1'b0;
            low_side_drive[ch] <= ov_low_hold && s_ovl[ch];
            if (cycled)
              state <= `ST_OFF;
          end
          default: state <= `ST_OFF;
        endcase
        // Own enable, shared supply and shared thermal override everything.
        // Drives always go off; a thermal stop leaves the overvoltage latch
        // in place, so it cannot be used to sneak the high side back on.
        if (!run_ok) begin
          high_side_drive[ch]  <= 1'b0;
          low_side_drive[ch]   <= 1'b0;
          output_ok_flag[ch]   <= 1'b0;
          if (!(state == `ST_OVLATCH && s_en[ch] && s_vld)) begin
            state                <= `ST_OFF;
            soft_start_reset[ch] <= 1'b1;
            overcurrent_flag[ch] <= 1'b0;
          end
        end
      end
    end
  end
endgenerate

endmodule // converter_fault_protection_fsm

// ### hdl/fault_defs.vh
// Purpose: Constants for the converter fault supervisor.
// Assumes: 250 MHz ref_clk, 4 ns period.
// Notes:   Times are kept in their own units; the sample, blanking and overvoltage delay counts derive from them.
`ifndef FAULT_DEFS_VH
`define FAULT_DEFS_VH
`define CLK_PERIOD_PS      4000
`define SAMPLE_TIME_PS     40000
`define SAMPLE_CYCLES      ((`SAMPLE_TIME_PS) / (`CLK_PERIOD_PS))
`define BLANK_TIME_US      2480
`define BLANK_CYCLES       ((`BLANK_TIME_US * 1000000) / (`CLK_PERIOD_PS))
`define OV_DELAY_NS        200
`define OV_DELAY_CYCLES    ((`OV_DELAY_NS * 1000) / (`CLK_PERIOD_PS))
`define PERIOD_CYCLES      9'd400
`define EIGHTH_CYCLES      9'd50
`define PULSES_PER_STEP    5'd16
`define PREBIAS_STEPS      4'd8
`define SS_TOP             16'hffff
`define ST_OFF             3'h0
`define ST_PREBIAS         3'h1
`define ST_RUN             3'h2
`define ST_HICCUP          3'h3
`define ST_OVLATCH         3'h4
`endif

// ### dv/plant_model.sv
// Purpose: Model of the power stage and feedback comparators.
// Assumes: Bench commands a shorted load or an open feedback divider.
// Notes:   Switch current is only sensed while the low side conducts.
`timescale 1ns/100ps
module plant_model (
  // Drive from the supervisor and bench commands.
  input  wire [1:0] low_side_drive,
  input  wire [1:0] short_cmd,
  input  wire [1:0] fb_open,
  // Comparator outputs.
  output wire [1:0] overcurrent_cmp,
  output wire [1:0] feedback_input_above_070,
  output wire [1:0] feedback_input_above_075
);
  assign overcurrent_cmp          = short_cmd & low_side_drive;
  assign feedback_input_above_070 = ~fb_open;
  assign feedback_input_above_075 = ~fb_open;
endmodule // plant_model

// ### dv/fault_checker.sv
// Purpose: Concurrent checks on the fault supervisor ports.
// Assumes: One clock, synchronous active-low reset.
// Notes:   Input paths take up to four edges through the synchronisers.
`timescale 1ns/100ps
module fault_checker #(
  parameter [31:0] BLANK_CYCLES = 32'd100
) (
  // Clock and reset.
  input wire       ref_clk,
  input wire       nrst,
  // Watched ports.
  input wire [1:0] enable,
  input wire [1:0] sense_above_ov_low,
  input wire [1:0] high_side_drive,
  input wire [1:0] low_side_drive,
  input wire [1:0] soft_start_reset,
  input wire [1:0] output_ok_flag,
  input wire [1:0] overcurrent_flag,
  input wire [1:0] overvoltage_flag,
  input wire [1:0] open_loop_guard,
  input wire       thermal_shutdown
);
  reg [31:0] blank_cnt;
  always @(posedge ref_clk) begin
    if (!nrst || !overcurrent_flag[0])
      blank_cnt <= 32'h0;
    else
      blank_cnt <= blank_cnt + 32'h1;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  sequence hiccup_hold;
    (overcurrent_flag[0] && soft_start_reset[0] && !output_ok_flag[0])[*8];
  endsequence
  sequence ov_response;
    !high_side_drive[1] && low_side_drive[1] && !output_ok_flag[1];
  endsequence
  chk_hiccup_hold: assert property ($rose(overcurrent_flag[0]) |-> hiccup_hold)
    else $error("hiccup entry wrong");
  chk_blank_length: assert property ($fell(overcurrent_flag[0]) |-> blank_cnt >= BLANK_CYCLES - 2)
    else $error("blanking too short");
  chk_ov_entry: assert property ($rose(overvoltage_flag[1]) |-> ov_response)
    else $error("overvoltage response wrong");
  chk_ov_release: assert property ($fell(sense_above_ov_low[1]) && overvoltage_flag[1]
    |-> ##[1:6] !low_side_drive[1]) else $error("low side not released");
  chk_ov_latch: assert property (overvoltage_flag[1] |-> !high_side_drive[1])
    else $error("high side on while latched");
  chk_thermal_off: assert property (thermal_shutdown |=> !high_side_drive && !low_side_drive)
    else $error("drive during thermal stop");
  chk_open_stop: assert property (open_loop_guard[0] |-> !high_side_drive[0] && !output_ok_flag[0])
    else $error("open loop not stopped");
  chk_enable_off: assert property (!enable[1] [*6] |=> !high_side_drive[1] && !low_side_drive[1])
    else $error("disabled channel drives");
  chk_high_after_set: assert property ($fell(low_side_drive[0]) && output_ok_flag[0]
    |-> ##[0:1] high_side_drive[0]) else $error("high side late");
endmodule // fault_checker
bind converter_fault_protection_fsm fault_checker #(.BLANK_CYCLES(BLANK_CYCLES)) fault_checker_inst (
  .ref_clk(ref_clk), .nrst(nrst), .enable(enable), .sense_above_ov_low(sense_above_ov_low),
  .high_side_drive(high_side_drive), .low_side_drive(low_side_drive),
  .soft_start_reset(soft_start_reset), .output_ok_flag(output_ok_flag),
  .overcurrent_flag(overcurrent_flag), .overvoltage_flag(overvoltage_flag),
  .open_loop_guard(open_loop_guard), .thermal_shutdown(thermal_shutdown));

// ### dv/testbench.sv
// Purpose: Directed bench for the converter fault supervisor.
// Assumes: Short blanking parameter; pre-bias runs at full length once.
// Notes:   Waits sample 1 ns after an edge so registered outputs have settled.
`timescale 1ns/100ps
module testbench;
  localparam integer BLANK = 200;
  reg        ref_clk = 1'b0;
  reg        nrst = 1'b0;
  reg        supply_valid = 1'b0;
  reg        over_temp = 1'b0;
  reg        track_near_ref = 1'b0;
  reg  [1:0] enable = 2'h0;
  reg  [1:0] short_cmd = 2'h0;
  reg  [1:0] fb_open = 2'h0;
  reg  [1:0] ov = 2'h0;
  reg  [1:0] ov_low = 2'h0;
  wire [1:0] oc_cmp, fb70, fb75, hs, ls, ssr, ok, ocf, ovf, olg;
  wire       tsd, iref;
  integer    fail_count = 0;
  integer    checks = 0;
  integer    n;
  always #2 ref_clk = ~ref_clk;
  plant_model plant_model_inst (.low_side_drive(ls), .short_cmd(short_cmd), .fb_open(fb_open),
    .overcurrent_cmp(oc_cmp), .feedback_input_above_070(fb70), .feedback_input_above_075(fb75));
  converter_fault_protection_fsm #(.BLANK_CYCLES(BLANK)) converter_fault_protection_fsm_inst (
    .ref_clk(ref_clk), .nrst(nrst), .supply_valid(supply_valid), .enable(enable),
    .overcurrent_cmp(oc_cmp), .sense_above_ov(ov), .sense_above_ov_low(ov_low),
    .sense_above_085(2'h3), .sense_above_080(2'h3), .feedback_input_above_070(fb70),
    .feedback_input_above_075(fb75), .over_temp(over_temp), .track_near_ref(track_near_ref),
    .high_side_drive(hs), .low_side_drive(ls), .soft_start_reset(ssr), .output_ok_flag(ok),
    .overcurrent_flag(ocf), .overvoltage_flag(ovf), .open_loop_guard(olg),
    .thermal_shutdown(tsd), .ch2_use_internal_ref(iref));
  task results;
    begin
      if (fail_count == 0 && checks > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      checks = checks + 1;
      if (seen !== exp) begin
        fail_count = fail_count + 1;
        $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
      end
    end
  endtask
  function sel(input integer id);
    case (id)
      0: sel = ssr[0];
      1: sel = ocf[0];
      2: sel = olg[0];
      3: sel = ovf[1];
      4: sel = ls[1];
      5: sel = tsd;
      6: sel = ls[0];
      7: sel = iref;
      default: sel = hs[0];
    endcase
  endfunction
  // Counts edges until the watched output takes the value; n holds the count.
  task wait_for(input integer id, input v, input integer bound);
    begin
      n = 0;
      do begin
        @(posedge ref_clk);
        #1 n = n + 1;
      end while (sel(id) !== v && n < bound);
      if (sel(id) !== v) begin
        chk(0, 1);
        results;
      end
    end
  endtask
  initial begin
    repeat (6) @(posedge ref_clk);
    #1 chk({hs, ls, ssr, ok, ocf, ovf, olg, tsd}, 15'h0600);
    @(posedge ref_clk) {nrst, supply_valid, enable} <= 4'hf;
    wait_for(6, 1, 100);
    wait_for(6, 0, 100);
    wait_for(6, 1, 400);
    wait_for(6, 0, 100);
    chk(n, 50);
    wait_for(0, 0, 60000);
    repeat (500) @(posedge ref_clk);
    #1 chk({ok, iref}, 3'h6);
    @(posedge ref_clk) track_near_ref <= 1'b1;
    wait_for(7, 1, 8);
    @(posedge ref_clk) fb_open <= 2'h1;
    wait_for(2, 1, 8);
    chk({hs[0], ls[0], ok}, 4'h2);
    @(posedge ref_clk) fb_open <= 2'h0;
    wait_for(2, 0, 8);
    wait_for(8, 1, 500);
    @(posedge ref_clk) short_cmd <= 2'h1;
    wait_for(1, 1, 900);
    chk({hs[0], ls[0], ok, ssr[0]}, 5'h5);
    wait_for(1, 0, BLANK + 50);
    chk(n >= BLANK - 2 && n <= BLANK + 2, 1);
    wait_for(1, 1, 900);
    @(posedge ref_clk) short_cmd <= 2'h0;
    wait_for(1, 0, BLANK + 50);
    wait_for(6, 1, 500);
    wait_for(6, 0, 100);
    chk(n, 50);
    chk(ssr[0], 1);
    @(posedge ref_clk) {ov, ov_low} <= 4'ha;
    wait_for(3, 1, 100);
    chk({hs[1], ls[1], ok[1]}, 3'h2);
    @(posedge ref_clk) {ov, ov_low} <= 4'h0;
    wait_for(4, 0, 10);
    repeat (1000) @(posedge ref_clk);
    #1 chk({hs[1], ovf[1]}, 2'h1);
    @(posedge ref_clk) enable <= 2'h1;
    repeat (10) @(posedge ref_clk);
    #1 chk({hs[1], ls[1], ssr[0]}, 3'h1);
    @(posedge ref_clk) enable <= 2'h3;
    wait_for(4, 1, 1000);
    chk(ovf[1], 0);
    @(posedge ref_clk) over_temp <= 1'b1;
    wait_for(5, 1, 8);
    @(posedge ref_clk);
    #1 chk({hs, ls}, 4'h0);
    @(posedge ref_clk) over_temp <= 1'b0;
    wait_for(5, 0, 8);
    wait_for(6, 1, 1000);
    results;
  end
endmodule // testbench
